//--- core_ptr_pkg.sv
// Constants for the pointer registers and the hardware return stack.
// Assumes one 8-bit system register address space in bank 0.
package core_ptr_pkg;
   localparam logic [7:0] ADDR_FIRST_LOW   = 8'h80;
   localparam logic [7:0] ADDR_FIRST_HIGH  = 8'h81;
   localparam logic [7:0] ADDR_TABLE_HIGH  = 8'h82;
   localparam logic [7:0] ADDR_SECOND_LOW  = 8'h83;
   localparam logic [7:0] ADDR_SECOND_HIGH = 8'h84;
   localparam logic [7:0] ADDR_SPARE       = 8'h85;
   localparam logic [7:0] ADDR_STATUS      = 8'h86;
   localparam logic [7:0] ADDR_STACK_PTR   = 8'hef;
   localparam logic [3:0] STACK_AREA_TOP   = 4'hf;
   localparam logic [3:0] WORK_AREA_TOP    = 4'h8;
   localparam int         OVF_BIT          = 4;
   localparam int         GIE_BIT          = 7;
   localparam logic [2:0] SP_RESET         = 3'h7;
   localparam logic [3:0] FULL_DEPTH       = 4'h8;
   localparam int         ENTRY_HIGH_W     = 4;
   localparam int         ENTRY_LOW_W      = 8;
endpackage : core_ptr_pkg

//--- core_pointer_regs_and_return_stack.sv
// Pointer, table and spare working registers plus the 8-level return
// stack with its sticky overflow flag.
// Assumes the instruction sequencer issues at most one push or pop per
// cycle and accesses system registers over the plain address port below.
//
// Overview of operation
// - First pair indirect: high bank, low location
// - Second pair indirect: high bank, low location
// - Lookup uses second pair; high to table-high
// - Immediate loads only into 0x80 to 0x8F
// - Bank-zero move reads/writes bank 0 location
// - Eight-entry LIFO stack of saved counters
// - Push on call/interrupt, pop on return
// - Three-bit stack pointer, resets to 111
// - Push decrements, pop increments, modulo eight
// - Push writes entry at inverted old pointer
// - Both returns restore newest entry, then increment
// - Ninth push sets overflow, keeps no entry
// - Overflow flag is read-only status bit 4
// - Overflow ignores writes, cleared only by reset
// - Entries readable/writable as high/low, reset zero
// - Pointer and entries mapped in bank 0
// - Pointer/table/spare registers RW, no reset value
// - First pair high at 081H, low 080H
`timescale 1ns/1ps
module core_pointer_regs_and_return_stack
   import core_ptr_pkg::*;
#(
   parameter int DEPTH = 8,
   parameter int PC_W  = ENTRY_HIGH_W + ENTRY_LOW_W
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rstn_i,
   input  wire logic              clk_en_i,
   input  wire logic [7:0]        sreg_addr_i,
   input  wire logic              sreg_wr_i,
   input  wire logic              sreg_rd_i,
   input  wire logic [7:0]        sreg_wdata_i,
   input  wire logic              imm_wr_i,
   input  wire logic [7:0]        imm_addr_i,
   input  wire logic [7:0]        imm_data_i,
   input  wire logic              push_i,
   input  wire logic              subroutine_return_i,
   input  wire logic              interrupt_return_i,
   input  wire logic [PC_W-1:0]   pc_i,
   input  wire logic              lookup_i,
   input  wire logic [15:0]       rom_word_i,
   output logic [7:0]             sreg_rdata_o,
   output logic                   imm_refused_o,
   output logic [15:0]            first_pair_indirect_o,
   output logic [15:0]            second_pair_indirect_o,
   output logic [7:0]             accumulator_o,
   output logic                   acc_load_o,
   output logic [PC_W-1:0]        restore_pc_o,
   output logic                   restore_valid_o,
   output logic [2:0]             return_stack_pointer_o,
   output logic                   return_overflow_flag_o
);

   // Entry n low sits at 0FEH - 2n, high at 0FFH - 2n
   function automatic logic [2:0] entry_of(input logic [7:0] a);
      entry_of = ~a[3:1];
   endfunction : entry_of

   function automatic logic in_stack_area(input logic [7:0] a);
      in_stack_area = (a[7:4] == STACK_AREA_TOP);
   endfunction : in_stack_area

   logic [7:0]        first_ptr_low_q;
   logic [7:0]        first_ptr_high_q;
   logic [7:0]        table_high_byte_q;
   logic [7:0]        second_ptr_low_q;
   logic [7:0]        second_ptr_high_q;
   logic [7:0]        spare_work_byte_q;
   logic [2:0]        sp_q;
   logic              gie_q;
   logic              ovf_q;
   logic [3:0]        depth_q;
   logic [3:0]        depth_d;
   logic [ENTRY_HIGH_W-1:0] ent_high_q [DEPTH];
   logic [ENTRY_LOW_W-1:0]  ent_low_q  [DEPTH];
   logic [7:0]        sreg_rdata_q;
   logic              imm_refused_q;
   logic [7:0]        acc_q;
   logic              acc_load_q;
   logic [PC_W-1:0]   restore_pc_q;
   logic              restore_valid_q;

   // Write port: bank-zero moves and the immediate path share one decoder
   wire        imm_ok   = (imm_addr_i[7:4] == WORK_AREA_TOP);
   wire        imm_take = imm_wr_i & imm_ok;
   wire        wr_en    = sreg_wr_i | imm_take;
   wire [7:0]  wr_addr  = imm_take ? imm_addr_i : sreg_addr_i;
   wire [7:0]  wr_data  = imm_take ? imm_data_i : sreg_wdata_i;
   wire        pop      = subroutine_return_i | interrupt_return_i;
   wire        do_push  = push_i;
   // Push wins if the sequencer ever raises both
   wire        do_pop   = pop & ~push_i;
   wire [2:0]  push_idx = ~sp_q;
   wire [2:0]  sp_up    = sp_q + 3'h1;
   wire [2:0]  pop_idx  = ~sp_up;
   wire        overflow = do_push & (depth_q >= FULL_DEPTH);
   wire        wr_sp    = wr_en & (wr_addr == ADDR_STACK_PTR);
   wire [2:0]  rd_idx   = entry_of(sreg_addr_i);
   wire [2:0]  wr_idx   = entry_of(wr_addr);
   wire        wr_stack = wr_en & in_stack_area(wr_addr);
   // Odd addresses in the stack area hold the upper counter bits
   wire        wr_hi    = wr_addr[0];

   // Named write selects keep the register processes free of decoding
   wire        wr_first_lo  = wr_en & (wr_addr == ADDR_FIRST_LOW);
   wire        wr_first_hi  = wr_en & (wr_addr == ADDR_FIRST_HIGH);
   wire        wr_second_lo = wr_en & (wr_addr == ADDR_SECOND_LOW);
   wire        wr_second_hi = wr_en & (wr_addr == ADDR_SECOND_HIGH);
   wire        wr_spare     = wr_en & (wr_addr == ADDR_SPARE);
   wire        wr_table     = wr_en & (wr_addr == ADDR_TABLE_HIGH);

   // Word restored by a pop; an empty pop still returns what is stored
   wire [PC_W-1:0] pop_word = {ent_high_q[pop_idx],
                               ent_low_q[pop_idx]};

   logic [2:0] sp_d;
   logic       gie_d;
   logic       ovf_d;

   // Read mux; bits that do not belong to this block read as zero
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (sreg_addr_i)
         ADDR_FIRST_LOW:   rd_mux = first_ptr_low_q;
         ADDR_FIRST_HIGH:  rd_mux = first_ptr_high_q;
         ADDR_TABLE_HIGH:  rd_mux = table_high_byte_q;
         ADDR_SECOND_LOW:  rd_mux = second_ptr_low_q;
         ADDR_SECOND_HIGH: rd_mux = second_ptr_high_q;
         ADDR_SPARE:       rd_mux = spare_work_byte_q;
         ADDR_STATUS:      rd_mux[OVF_BIT] = ovf_q;
         ADDR_STACK_PTR: begin
            rd_mux[2:0]     = sp_q;
            rd_mux[GIE_BIT] = gie_q;
         end
         default: begin
            if (in_stack_area(sreg_addr_i)) begin
               if (sreg_addr_i[0]) begin
                  rd_mux[ENTRY_HIGH_W-1:0] = ent_high_q[rd_idx];
               end else begin
                  rd_mux = ent_low_q[rd_idx];
               end
            end
         end
      endcase
   end

   // The pointer alone cannot tell a full stack from an empty one, as
   // both read 111, so a separate saturating depth count decides when
   // a push overflows. Software re-basing the pointer clears the count.
   always_comb begin
      depth_d = depth_q;
      if (wr_sp) begin
         // Software re-basing the pointer starts a fresh stack
         depth_d = 4'h0;
      end else if (do_push && depth_q < FULL_DEPTH + 4'h1) begin
         depth_d = depth_q + 4'h1;
      end else if (do_pop && depth_q != 4'h0) begin
         depth_d = depth_q - 4'h1;
      end
   end

   // Stack traffic beats a software pointer write in the same cycle
   always_comb begin
      sp_d = sp_q;
      if (do_push) begin
         sp_d = sp_q - 3'h1;
      end else if (do_pop) begin
         sp_d = sp_up;
      end else if (wr_sp) begin
         sp_d = wr_data[2:0];
      end
   end

   always_comb begin
      gie_d = gie_q;
      if (wr_sp) begin
         gie_d = wr_data[GIE_BIT];
      end
   end

   // Set only; no write path reaches the flag, so only reset clears it
   always_comb begin
      ovf_d = ovf_q;
      if (overflow) begin
         ovf_d = 1'b1;
      end
   end

   // Working registers carry no reset: their power-up value is undefined
   always_ff @(posedge ref_clk_i) begin
      if (clk_en_i) begin
         if (wr_first_lo) begin
            first_ptr_low_q <= wr_data;
         end
         if (wr_first_hi) begin
            first_ptr_high_q <= wr_data;
         end
         if (wr_second_lo) begin
            second_ptr_low_q <= wr_data;
         end
         if (wr_second_hi) begin
            second_ptr_high_q <= wr_data;
         end
         if (wr_spare) begin
            spare_work_byte_q <= wr_data;
         end
      end
   end

   // Lookup result beats a same-cycle software write
   always_ff @(posedge ref_clk_i) begin
      if (clk_en_i) begin
         if (lookup_i) begin
            table_high_byte_q <= rom_word_i[15:8];
         end else if (wr_table) begin
            table_high_byte_q <= wr_data;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         sp_q    <= SP_RESET;
         gie_q   <= 1'b0;
         ovf_q   <= 1'b0;
         depth_q <= 4'h0;
      end else if (clk_en_i) begin
         depth_q <= depth_d;
         sp_q    <= sp_d;
         gie_q   <= gie_d;
         ovf_q   <= ovf_d;
      end
   end

   // One storage slot per level; the push path beats a software write
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_entry
         wire hit_push = do_push & ~overflow & (push_idx == 3'(g));
         wire hit_wr   = wr_stack & (wr_idx == 3'(g));
         always_ff @(posedge ref_clk_i) begin
            if (!rstn_i) begin
               ent_high_q[g] <= '0;
               ent_low_q[g]  <= '0;
            end else if (clk_en_i) begin
               if (hit_push) begin
                  ent_high_q[g] <= pc_i[PC_W-1:ENTRY_LOW_W];
                  ent_low_q[g]  <= pc_i[ENTRY_LOW_W-1:0];
               end else if (hit_wr && wr_hi) begin
                  ent_high_q[g] <= wr_data[ENTRY_HIGH_W-1:0];
               end else if (hit_wr) begin
                  ent_low_q[g]  <= wr_data;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         sreg_rdata_q    <= 8'h00;
         imm_refused_q   <= 1'b0;
         acc_q           <= 8'h00;
         acc_load_q      <= 1'b0;
         restore_pc_q    <= '0;
         restore_valid_q <= 1'b0;
      end else if (clk_en_i) begin
         imm_refused_q   <= imm_wr_i & ~imm_ok;
         acc_load_q      <= lookup_i | sreg_rd_i;
         restore_valid_q <= do_pop;
         if (sreg_rd_i) sreg_rdata_q <= rd_mux;
         if (lookup_i) begin
            acc_q <= rom_word_i[7:0];
         end else if (sreg_rd_i) begin
            acc_q <= rd_mux;
         end
         if (do_pop) begin
            restore_pc_q <= pop_word;
         end
      end
   end

   assign first_pair_indirect_o  = {first_ptr_high_q, first_ptr_low_q};
   assign second_pair_indirect_o = {second_ptr_high_q, second_ptr_low_q};
   assign sreg_rdata_o           = sreg_rdata_q;
   assign imm_refused_o          = imm_refused_q;
   assign accumulator_o          = acc_q;
   assign acc_load_o             = acc_load_q;
   assign restore_pc_o           = restore_pc_q;
   assign restore_valid_o        = restore_valid_q;
   assign return_stack_pointer_o = sp_q;
   assign return_overflow_flag_o = ovf_q;

endmodule : core_pointer_regs_and_return_stack

//--- core_ptr_chk.sv
// Concurrent checks on the top ports of the pointer and return stack block.
// Bound from the testbench; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module core_ptr_chk
   import core_ptr_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        rstn_i,
   input wire logic        clk_en_i,
   input wire logic [7:0]  sreg_addr_i,
   input wire logic        sreg_rd_i,
   input wire logic        imm_wr_i,
   input wire logic [7:0]  imm_addr_i,
   input wire logic        push_i,
   input wire logic        subroutine_return_i,
   input wire logic        interrupt_return_i,
   input wire logic        lookup_i,
   input wire logic [15:0] rom_word_i,
   input wire logic [7:0]  sreg_rdata_o,
   input wire logic        imm_refused_o,
   input wire logic [7:0]  accumulator_o,
   input wire logic        acc_load_o,
   input wire logic        restore_valid_o,
   input wire logic [2:0]  return_stack_pointer_o,
   input wire logic        return_overflow_flag_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   wire logic [7:0] rom_lo = rom_word_i[7:0];
   wire logic       pop = (subroutine_return_i | interrupt_return_i) & ~push_i;
   a_push_ptr_dec: assert property (
      push_i && clk_en_i |=> return_stack_pointer_o ==
      $past(return_stack_pointer_o) - 3'h1) else $error("push pointer");
   a_pop_ptr_inc: assert property (
      pop && clk_en_i |=> restore_valid_o && return_stack_pointer_o ==
      $past(return_stack_pointer_o) + 3'h1) else $error("pop pointer");
   a_ovf_sticky: assert property (
      return_overflow_flag_o |=> return_overflow_flag_o)
      else $error("overflow flag dropped");
   a_ovf_cause: assert property (
      $rose(return_overflow_flag_o) |-> $past(push_i))
      else $error("overflow without push");
   a_imm_refuse: assert property (
      imm_wr_i && clk_en_i && imm_addr_i[7:4] != 4'h8 |=> imm_refused_o)
      else $error("immediate not refused");
   a_imm_accept: assert property (
      imm_wr_i && clk_en_i && imm_addr_i[7:4] == 4'h8 |=> !imm_refused_o)
      else $error("immediate refused");
   a_lookup_acc: assert property (
      lookup_i && clk_en_i |=> acc_load_o && accumulator_o == $past(rom_lo))
      else $error("lookup low byte");
   a_status_read: assert property (
      sreg_rd_i && clk_en_i && !lookup_i && sreg_addr_i == ADDR_STATUS |=>
      sreg_rdata_o == {3'h0, $past(return_overflow_flag_o), 4'h0})
      else $error("status read");
   a_reset_state: assert property (disable iff (1'b0)
      !rstn_i && clk_en_i |=> return_stack_pointer_o == SP_RESET &&
      !return_overflow_flag_o) else $error("reset state");
endmodule : core_ptr_chk

//--- ret_seq_model.sv
// Instruction sequencer stand-in: issues calls and returns to the stack.
// Strobes change just after a rising edge and last one cycle.
`timescale 1ns/1ps
module ret_seq_model (
   input  wire logic   clk_i,
   output logic        push_o = 1'b0,
   output logic        sub_ret_o = 1'b0,
   output logic        irq_ret_o = 1'b0,
   output logic [11:0] pc_o = 12'h000
);
   task automatic call_op(input logic [11:0] pc);
      @(posedge clk_i);
      push_o <= 1'b1;
      pc_o <= pc;
      @(posedge clk_i);
      push_o <= 1'b0;
      // The counter is not held after the push, so show a changed value
      pc_o <= ~pc;
   endtask : call_op
   task automatic ret_op(input logic from_irq);
      @(posedge clk_i);
      sub_ret_o <= ~from_irq;
      irq_ret_o <= from_irq;
      @(posedge clk_i);
      sub_ret_o <= 1'b0;
      irq_ret_o <= 1'b0;
   endtask : ret_op
endmodule : ret_seq_model

//--- tb_core_pointer_regs_and_return_stack.sv
// Self-checking bench: register, lookup and stack traffic against a model.
// Clock enable is high except for one write cycle; the sequencer model drives the stack strobes.
`timescale 1ns/1ps
module tb_core_pointer_regs_and_return_stack;
   import core_ptr_pkg::*;
   logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, imm = 1'b0;
   logic        lkp = 1'b0, push, sub, irq, rv, refd, ld, ovf, m_ovf;
   logic        en = 1'b1;
   logic [7:0]  addr = 8'h00, wd = 8'h00, ia = 8'h00, idat = 8'h00, rdat, acc;
   logic [7:0]  v, w;
   logic [11:0] pc, rpc;
   logic [11:0] ent [8];
   logic [15:0] rom = 16'h0000, p1, p2, r;
   logic [2:0]  sp_o, sp;
   int          depth, i, fails = 0, cmp_count = 0;
   always #50 clk = ~clk;
   ret_seq_model seq_u (.clk_i(clk), .push_o(push), .sub_ret_o(sub),
      .irq_ret_o(irq), .pc_o(pc));
   core_pointer_regs_and_return_stack dut_u (.ref_clk_i(clk), .rstn_i(rstn),
      .clk_en_i(en), .sreg_addr_i(addr), .sreg_wr_i(wr), .sreg_rd_i(rd),
      .sreg_wdata_i(wd), .imm_wr_i(imm), .imm_addr_i(ia), .imm_data_i(idat),
      .push_i(push), .subroutine_return_i(sub), .interrupt_return_i(irq),
      .pc_i(pc), .lookup_i(lkp), .rom_word_i(rom), .sreg_rdata_o(rdat),
      .imm_refused_o(refd), .first_pair_indirect_o(p1),
      .second_pair_indirect_o(p2), .accumulator_o(acc), .acc_load_o(ld),
      .restore_pc_o(rpc), .restore_valid_o(rv),
      .return_stack_pointer_o(sp_o), .return_overflow_flag_o(ovf));
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic sw(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      #1;
   endtask : sw
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(16'(rdat), 16'(e));
      chk(16'(acc), 16'(e));
   endtask : rchk
   task automatic imw(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      ia <= a;
      idat <= d;
      imm <= 1'b1;
      @(posedge clk);
      imm <= 1'b0;
      #1;
      chk(16'(refd), 16'(a[7:4] != 4'h8));
   endtask : imw
   task automatic do_push(input logic [11:0] x);
      seq_u.call_op(x);
      #1;
      if (depth >= 8) m_ovf = 1'b1;
      else ent[~sp] = x;
      if (depth < 9) depth++;
      sp = sp - 3'h1;
      chk(16'(sp_o), 16'(sp));
      chk(16'(ovf), 16'(m_ovf));
   endtask : do_push
   task automatic do_pop(input logic k);
      seq_u.ret_op(k);
      #1;
      sp = sp + 3'h1;
      if (depth > 0) depth--;
      chk(16'(rpc), 16'(ent[~sp]));
      chk(16'({rv, sp_o}), 16'({1'b1, sp}));
   endtask : do_pop
   task automatic rst;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      sp = SP_RESET;
      depth = 0;
      m_ovf = 1'b0;
      foreach (ent[j]) ent[j] = 12'h000;
   endtask : rst
   initial begin
      #1000000;
      fails++;
      finish_test();
   end
   initial begin
      void'($urandom(61));
      rst();
      rchk(ADDR_STACK_PTR, 8'h07);
      rchk(ADDR_STATUS, 8'h00);
      sw(ADDR_STACK_PTR, 8'h07);
      for (i = 0; i < 3; i++) begin
         v = 8'($urandom);
         w = 8'($urandom);
         r = 16'($urandom);
         sw(ADDR_FIRST_HIGH, v);
         sw(ADDR_FIRST_LOW, w);
         chk(p1, {v, w});
         imw(ADDR_SECOND_HIGH, w);
         imw(ADDR_SECOND_LOW, v);
         imw(8'h90, v);
         chk(p2, {w, v});
         @(posedge clk);
         lkp <= 1'b1;
         rom <= r;
         @(posedge clk);
         lkp <= 1'b0;
         rom <= ~r;
         #1;
         chk({ld, 7'h00, acc}, {1'b1, 7'h00, r[7:0]});
         rchk(ADDR_TABLE_HIGH, r[15:8]);
         sw(ADDR_SPARE, v);
         rchk(ADDR_SPARE, v);
         rchk(8'h90, 8'h00);
      end
      // A write while the clock enable is low must leave the byte alone
      @(posedge clk);
      en <= 1'b0;
      addr <= ADDR_SPARE;
      wd <= ~v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      en <= 1'b1;
      rchk(ADDR_SPARE, v);
      for (i = 0; i < 8; i++) do_push(12'($urandom));
      for (i = 0; i < 8; i++) begin
         rchk(8'hfe - 8'(2 * i), ent[i][7:0]);
         rchk(8'hff - 8'(2 * i), {4'h0, ent[i][11:8]});
      end
      sw(8'hfe, 8'h5a);
      ent[0][7:0] = 8'h5a;
      rchk(8'hfe, 8'h5a);
      for (i = 0; i < 9; i++) do_pop(i[0]);
      sw(ADDR_STACK_PTR, 8'h07);
      sp = SP_RESET;
      depth = 0;
      for (i = 0; i < 10; i++) do_push(12'($urandom));
      sw(ADDR_STATUS, 8'h00);
      rchk(ADDR_STATUS, 8'h10);
      rst();
      rchk(ADDR_STATUS, 8'h00);
      finish_test();
   end
endmodule : tb_core_pointer_regs_and_return_stack
bind core_pointer_regs_and_return_stack core_ptr_chk chk_u (.*);
